// File: inc/smic_pkg.sv
package smic_pkg;
    // apb carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } smic_apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } smic_apb_rsp_t;

    // register byte addresses
    localparam logic [7:0] ADDR_MODE     = 8'h00;
    localparam logic [7:0] ADDR_CONFIG   = 8'h04;
    localparam logic [7:0] ADDR_PRESCALE = 8'h08;
    localparam logic [7:0] ADDR_TIMER    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS   = 8'h10;
    localparam logic [7:0] ADDR_MASK     = 8'h14;
    localparam logic [7:0] ADDR_TEMP     = 8'h18;
    localparam logic [7:0] ADDR_INDEX    = 8'h1C;
    localparam logic [7:0] ADDR_ACCUM    = 8'h20;
    localparam logic [7:0] ADDR_CONV     = 8'h24;

    // mode register fields
    localparam int unsigned MODE_W            = 8;
    localparam int unsigned MB_SYNTH_IRQ_EN   = 0;
    localparam int unsigned MB_PRED_SYNTH     = 1;
    localparam int unsigned MB_SAMPLE_MODE    = 2;
    localparam int unsigned MB_TIMER_IRQ_EN   = 3;
    localparam int unsigned MB_EXT_SPEECH_MEM = 4;
    // config register fields
    localparam int unsigned CB_RATE_SLOW = 0;
    localparam int unsigned CB_RES9      = 1;
    // status and mask fields
    localparam int unsigned IRQ_W       = 3;
    localparam int unsigned SB_SYNTH    = 0;
    localparam int unsigned SB_TIMER    = 1;
    localparam int unsigned SB_EXT      = 2;

    localparam int unsigned TEMP_W   = 14;
    localparam int unsigned INDEX_W  = 8;
    localparam int unsigned ACCUM_W  = 14;
    localparam int unsigned CONV_W   = 10;
    localparam int unsigned TIMER_W  = 8;
    localparam int unsigned PERIOD_W = 13;

    localparam logic [MODE_W-1:0]  MODE_RESET  = 8'h00;
    localparam logic [TIMER_W-1:0] TIMER_MAX   = 8'hFF;

    // timing
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned RATE_FAST_HZ = 20_000;
    localparam int unsigned RATE_SLOW_HZ = 16_000;

    typedef struct packed {
        smic_apb_rsp_t        rsp;
        logic [MODE_W-1:0]    mode;
        logic [1:0]           cfg;
        logic [TIMER_W-1:0]   prescale;
        logic [TIMER_W-1:0]   pre_cnt;
        logic [TIMER_W-1:0]   timer;
        logic [IRQ_W-1:0]     status;
        logic [IRQ_W-1:0]     mask;
        logic                 irq;
        logic [TEMP_W-1:0]    temp;
        logic [TEMP_W-1:0]    temp_save;
        logic [INDEX_W-1:0]   index;
        logic [ACCUM_W-1:0]   accum;
        logic [CONV_W-1:0]    conv;
        logic                 in_synth_isr;
        logic [1:0]           ext_sync;
        logic                 ext_last;
        logic                 phase;
        logic                 filter_req;
        logic                 take_synth;
        logic                 take_timer;
        logic                 synth_on;
    } smic_state_t;

    typedef struct packed {
        logic [PERIOD_W-1:0] cnt;
        logic [PERIOD_W-1:0] thresh;
        logic                pwm;
        logic                tick;
    } smic_pwm_state_t;
endpackage : smic_pkg

// File: rtl/smic_pwm.sv
`timescale 1ns/10ps
module smic_pwm (
    input  wire logic                            i_clk,
    input  wire logic                            i_reset,
    input  wire logic [smic_pkg::PERIOD_W-1:0]   i_period,
    input  wire logic [smic_pkg::CONV_W-1:0]     i_value,
    input  wire logic                            i_res9,
    output logic                                 o_pwm,
    output logic                                 o_sample_tick
);
    import smic_pkg::*;

    smic_pwm_state_t q;
    smic_pwm_state_t d;
    logic [CONV_W-1:0]            val;
    logic [PERIOD_W+CONV_W-1:0]   prod;

    // 9-bit resolution drops the lsb so the duty steps are coarser
    assign val  = i_res9 ? {i_value[CONV_W-1:1], 1'b0} : i_value;
    assign prod = (PERIOD_W+CONV_W)'(val) * (PERIOD_W+CONV_W)'(i_period);

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt >= i_period - PERIOD_W'(1)) begin
            d.cnt    = '0;
            d.tick   = 1'b1;
            d.thresh = prod[PERIOD_W+CONV_W-1:CONV_W];
        end else begin
            d.cnt = q.cnt + PERIOD_W'(1);
        end
        d.pwm = (d.cnt < d.thresh);
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_pwm         = q.pwm;
    assign o_sample_tick = q.tick;
endmodule : smic_pwm

// File: rtl/smic_top.sv
// Behaviour
// - mode bit 0 enables synthesis interrupt
// - mode bit 3 enables timer interrupt
// - timer overflow raises timer interrupt
// - synthesis interrupt wins; four mode-selected sources
// - mode bit 1 switches predictive synthesis
// - mode bit 4 enables external speech memory
// - temp saved on synth entry, restored on return
// - swap temp with index or accumulator
// - pwm converter, two samples per filter value
// - sample mode loads converter directly while mode bit 1 is clear
// - external interrupt from port b pin one
// - mode register eight bits, write only
// - mode bit 2 selects sample mode
// - 8-bit prescaler divides clock for timer
// - both synth bits clear disables synthesizer
`timescale 1ns/10ps
module smic_top #(
    parameter int unsigned P_FAST_CYCLES = smic_pkg::CLK_HZ / smic_pkg::RATE_FAST_HZ,
    parameter int unsigned P_SLOW_CYCLES = smic_pkg::CLK_HZ / smic_pkg::RATE_SLOW_HZ
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    input  wire smic_pkg::smic_apb_req_t        i_apb,
    output smic_pkg::smic_apb_rsp_t             o_apb,
    input  wire logic                           i_port_b_pin_one,
    input  wire logic [3:0]                     i_synth_cond,
    input  wire logic                           i_irq_enter_synth,
    input  wire logic                           i_irq_enter_timer,
    input  wire logic                           i_return_from_interrupt_instr,
    input  wire logic                           i_swap_temp_index_instr,
    input  wire logic                           i_swap_temp_accum_instr,
    input  wire logic                           i_filter_valid,
    input  wire logic [smic_pkg::CONV_W-1:0]    i_filter_value,
    output logic                                o_take_synth_irq,
    output logic                                o_take_timer_irq,
    output logic                                o_irq,
    output logic                                o_predictive_synth_enable,
    output logic                                o_sample_mode,
    output logic                                o_ext_speech_mem_enable,
    output logic                                o_synth_enable,
    output logic                                o_filter_req,
    output logic                                o_pwm
);
    import smic_pkg::*;

    smic_state_t            q;
    smic_state_t            d;
    logic                   setup;
    logic                   access;
    logic                   wr;
    logic [7:0]             waddr;
    logic [31:0]            wdata;
    logic                   pre_zero;
    logic                   tim_ovf;
    logic                   ext_rise;
    logic                   synth_evt;
    logic                   sample_tick;
    logic [PERIOD_W-1:0]    period;

    localparam logic [PERIOD_W-1:0] FAST_P = PERIOD_W'(P_FAST_CYCLES);
    localparam logic [PERIOD_W-1:0] SLOW_P = PERIOD_W'(P_SLOW_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // pready rises the cycle after setup, so every access takes one wait-free
    // access phase and read data is already registered when it is sampled
    assign setup  = i_apb.psel & ~i_apb.penable;
    assign access = i_apb.psel & i_apb.penable & q.rsp.pready;
    assign wr     = access & i_apb.pwrite;
    assign waddr  = i_apb.paddr;
    assign wdata  = i_apb.pwdata;

    ////////////////////////////////////////////////////////////////////////////
    // events

    assign pre_zero  = (q.pre_cnt == '0);
    assign tim_ovf   = pre_zero & (q.timer == TIMER_MAX);
    assign ext_rise  = q.ext_sync[1] & ~q.ext_last;
    // the two synth mode bits pick which of the four sources fires
    assign synth_evt = i_synth_cond[{q.mode[MB_SAMPLE_MODE], q.mode[MB_PRED_SYNTH]}];
    assign period    = q.cfg[CB_RATE_SLOW] ? SLOW_P : FAST_P;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        d = q;
        d.filter_req  = 1'b0;
        d.rsp.pready  = setup;
        d.rsp.pslverr = 1'b0;
        d.rsp.prdata  = '0;

        // read data captured in setup; mode reads as zero, it is write only
        if (setup & ~i_apb.pwrite) begin
            if (i_apb.paddr == ADDR_MODE) begin
                d.rsp.prdata = '0;
            end else if (i_apb.paddr == ADDR_CONFIG) begin
                d.rsp.prdata = 32'(q.cfg);
            end else if (i_apb.paddr == ADDR_PRESCALE) begin
                d.rsp.prdata = 32'(q.prescale);
            end else if (i_apb.paddr == ADDR_TIMER) begin
                d.rsp.prdata = 32'(q.timer);
            end else if (i_apb.paddr == ADDR_STATUS) begin
                d.rsp.prdata = 32'(q.status);
            end else if (i_apb.paddr == ADDR_MASK) begin
                d.rsp.prdata = 32'(q.mask);
            end else if (i_apb.paddr == ADDR_TEMP) begin
                d.rsp.prdata = 32'(q.temp);
            end else if (i_apb.paddr == ADDR_INDEX) begin
                d.rsp.prdata = 32'(q.index);
            end else if (i_apb.paddr == ADDR_ACCUM) begin
                d.rsp.prdata = 32'(q.accum);
            end else if (i_apb.paddr == ADDR_CONV) begin
                d.rsp.prdata = 32'(q.conv);
            end else begin
                d.rsp.pslverr = 1'b1;
            end
        end else if (setup) begin
            d.rsp.pslverr = (i_apb.paddr > ADDR_CONV) | (i_apb.paddr[1:0] != 2'b00);
        end

        // prescaler and timer
        if (pre_zero) begin
            d.pre_cnt = q.prescale;
            d.timer   = q.timer + TIMER_W'(1);
        end else begin
            d.pre_cnt = q.pre_cnt - TIMER_W'(1);
        end

        // external pin: two flops before anything looks at it
        d.ext_sync = {q.ext_sync[0], i_port_b_pin_one};
        d.ext_last = q.ext_sync[1];

        // register writes
        if (wr) begin
            if (waddr == ADDR_MODE) begin
                d.mode = wdata[MODE_W-1:0];
            end else if (waddr == ADDR_CONFIG) begin
                d.cfg = wdata[1:0];
            end else if (waddr == ADDR_PRESCALE) begin
                d.prescale = wdata[TIMER_W-1:0];
            end else if (waddr == ADDR_TIMER) begin
                d.timer = wdata[TIMER_W-1:0];
            end else if (waddr == ADDR_MASK) begin
                d.mask = wdata[IRQ_W-1:0];
            end else if (waddr == ADDR_TEMP) begin
                d.temp = wdata[TEMP_W-1:0];
            end else if (waddr == ADDR_INDEX) begin
                d.index = wdata[INDEX_W-1:0];
            end else if (waddr == ADDR_ACCUM) begin
                d.accum = wdata[ACCUM_W-1:0];
            end else if (waddr == ADDR_CONV && q.mode[MB_SAMPLE_MODE]
                         && !q.mode[MB_PRED_SYNTH]) begin
                d.conv = wdata[CONV_W-1:0];
            end
        end

        // sticky status: clears first, then sets, so a same-cycle event wins
        d.status = q.status;
        if (wr && waddr == ADDR_STATUS) begin
            d.status = q.status & ~wdata[IRQ_W-1:0];
        end
        if (i_irq_enter_synth) begin
            d.status[SB_SYNTH] = 1'b0;
        end
        if (i_irq_enter_timer) begin
            d.status[SB_TIMER] = 1'b0;
            d.status[SB_EXT]   = 1'b0;
        end
        if (synth_evt) begin
            d.status[SB_SYNTH] = 1'b1;
        end
        if (tim_ovf) begin
            d.status[SB_TIMER] = 1'b1;
        end
        if (ext_rise) begin
            d.status[SB_EXT] = 1'b1;
        end
        d.irq = |(d.status & d.mask);

        // temp register swaps, save and restore
        if (i_swap_temp_index_instr) begin
            d.temp  = TEMP_W'(q.index);
            d.index = q.temp[INDEX_W-1:0];
        end else if (i_swap_temp_accum_instr) begin
            d.temp  = q.accum;
            d.accum = q.temp;
        end
        if (i_irq_enter_synth) begin
            d.temp_save    = q.temp;
            d.in_synth_isr = 1'b1;
        end else if (i_return_from_interrupt_instr && q.in_synth_isr) begin
            d.temp         = q.temp_save;
            d.in_synth_isr = 1'b0;
        end

        // filter values feed the converter only while predictive synthesis (mode bit 1) is on;
        // each value is held for two converter samples
        if (q.mode[MB_PRED_SYNTH] && i_filter_valid) begin
            d.conv = i_filter_value;
        end
        if (sample_tick) begin
            d.phase      = ~q.phase;
            d.filter_req = q.phase & q.mode[MB_PRED_SYNTH];
        end

        // a pending source is only offered while its enable is set
        d.take_synth = q.status[SB_SYNTH] & q.mode[MB_SYNTH_IRQ_EN];
        d.take_timer = ~d.take_synth
                     & (q.status[SB_TIMER] | q.status[SB_EXT])
                     & q.mode[MB_TIMER_IRQ_EN];
        d.synth_on   = q.mode[MB_PRED_SYNTH] | q.mode[MB_SAMPLE_MODE];
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            q      <= '0;
            q.mode <= MODE_RESET;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // converter

    smic_pwm u_pwm (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_period      (period),
        .i_value       (q.conv),
        .i_res9        (q.cfg[CB_RES9]),
        .o_pwm         (o_pwm),
        .o_sample_tick (sample_tick)
    );

    assign o_apb                     = q.rsp;
    assign o_take_synth_irq          = q.take_synth;
    assign o_take_timer_irq          = q.take_timer;
    assign o_irq                     = q.irq;
    assign o_predictive_synth_enable = q.mode[MB_PRED_SYNTH];
    assign o_sample_mode             = q.mode[MB_SAMPLE_MODE];
    assign o_ext_speech_mem_enable   = q.mode[MB_EXT_SPEECH_MEM];
    assign o_synth_enable            = q.synth_on;
    assign o_filter_req              = q.filter_req;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    // interrupt offer, priority and flags
    a_synth_take_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        o_take_synth_irq |-> $past(q.mode[MB_SYNTH_IRQ_EN]) && $past(q.status[SB_SYNTH]))
        else $error("synth interrupt offered while disabled or idle");

    a_held_off: assert property (@(posedge i_clk) disable iff (i_reset)
        !q.mode[MB_SYNTH_IRQ_EN] |=> !o_take_synth_irq)
        else $error("synth interrupt offered while its enable is clear");

    a_timer_take_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        o_take_timer_irq |-> $past(q.mode[MB_TIMER_IRQ_EN]))
        else $error("timer interrupt offered while disabled");

    a_synth_priority: assert property (@(posedge i_clk) disable iff (i_reset)
        !(o_take_synth_irq && o_take_timer_irq))
        else $error("both interrupt levels offered");

    a_synth_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        synth_evt |=> q.status[SB_SYNTH])
        else $error("selected synth source did not flag");

    a_timer_ovf_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        (pre_zero && q.timer == TIMER_MAX && !(wr && waddr == ADDR_TIMER))
        |=> q.status[SB_TIMER] && q.timer == '0)
        else $error("timer overflow did not flag");

    a_prescale_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        (!pre_zero && !(wr && waddr == ADDR_TIMER)) |=> $stable(q.timer))
        else $error("timer moved between prescaler ticks");

    a_ext_pin_flag: assert property (@(posedge i_clk) disable iff (i_reset)
        $rose(q.ext_sync[1]) |=> q.status[SB_EXT])
        else $error("external pin edge not flagged");

    // mode bits
    a_pred_enable: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr && waddr == ADDR_MODE) |=> o_predictive_synth_enable == $past(wdata[1]))
        else $error("predictive enable did not follow mode write");

    a_sample_enable: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr && waddr == ADDR_MODE) |=> o_sample_mode == $past(wdata[MB_SAMPLE_MODE]))
        else $error("sample mode did not follow mode write");

    a_ext_mem_enable: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr && waddr == ADDR_MODE) |=> o_ext_speech_mem_enable == $past(wdata[4]))
        else $error("speech memory enable did not follow mode write");

    a_mode_readback: assert property (@(posedge i_clk) disable iff (i_reset)
        (setup && !i_apb.pwrite && i_apb.paddr == ADDR_MODE) |=> o_apb.prdata == '0)
        else $error("mode register read back nonzero");

    a_synth_off: assert property (@(posedge i_clk) disable iff (i_reset)
        (q.mode[2:1] == 2'b00) |=> !o_synth_enable)
        else $error("synthesizer on with both bits clear");

    // temp register
    a_temp_restore: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_return_from_interrupt_instr && q.in_synth_isr && !i_irq_enter_synth)
        |=> q.temp == $past(q.temp_save) && !q.in_synth_isr)
        else $error("temp not restored on return");

    a_swap_index: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_swap_temp_index_instr && !i_irq_enter_synth && !i_return_from_interrupt_instr)
        |=> q.index == $past(q.temp[INDEX_W-1:0]))
        else $error("index swap lost data");

    a_swap_accum: assert property (@(posedge i_clk) disable iff (i_reset)
        (i_swap_temp_accum_instr && !i_swap_temp_index_instr) |=> q.accum == $past(q.temp))
        else $error("accumulator swap lost data");

    // converter
    a_sample_direct: assert property (@(posedge i_clk) disable iff (i_reset)
        (wr && waddr == ADDR_CONV && q.mode[2:1] == 2'b10) |=> q.conv == $past(wdata[9:0]))
        else $error("sample write did not reach converter");

    a_conv_locked: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_filter_valid && !(wr && waddr == ADDR_CONV && q.mode[2:1] == 2'b10))
        |=> $stable(q.conv))
        else $error("converter changed without a load");

    a_filter_load: assert property (@(posedge i_clk) disable iff (i_reset)
        (q.mode[MB_PRED_SYNTH] && i_filter_valid) |=> q.conv == $past(i_filter_value))
        else $error("filter value did not reach converter");

    a_filter_pairs: assert property (@(posedge i_clk) disable iff (i_reset)
        o_filter_req |-> !q.phase)
        else $error("filter request not every second sample");

    c_synth_taken: cover property (@(posedge i_clk) disable iff (i_reset)
        o_take_synth_irq ##1 i_irq_enter_synth);
    c_timer_taken: cover property (@(posedge i_clk) disable iff (i_reset)
        o_take_timer_irq ##1 i_irq_enter_timer);
    c_filter_req: cover property (@(posedge i_clk) disable iff (i_reset) o_filter_req);
    c_temp_restore: cover property (@(posedge i_clk) disable iff (i_reset)
        i_return_from_interrupt_instr && q.in_synth_isr);
endmodule : smic_top

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import smic_pkg::*;
    logic              i_clk   = 1'b0;
    logic              i_reset = 1'b1;
    smic_apb_req_t     apb_req = '0;
    smic_apb_rsp_t     apb_rsp;
    logic [9:0]        pl      = '0; // conds, enter synth/timer, return_from_interrupt_instr, swaps, filter valid
    logic              pin     = 1'b0;
    logic [CONV_W-1:0] fval    = '0;
    logic              take_s, take_t, irq, pred, samp, extm, syn, freq, pwm;
    logic [31:0]       rd, t1, t2;
    logic              err;
    int                errors = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    int unsigned       m, k, j;

    always #5 i_clk = ~i_clk;

    smic_top #(.P_FAST_CYCLES(40), .P_SLOW_CYCLES(50)) dut_u (
        .i_clk(i_clk), .i_reset(i_reset), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_port_b_pin_one(pin), .i_synth_cond(pl[3:0]), .i_irq_enter_synth(pl[4]),
        .i_irq_enter_timer(pl[5]), .i_return_from_interrupt_instr(pl[6]),
        .i_swap_temp_index_instr(pl[7]), .i_swap_temp_accum_instr(pl[8]),
        .i_filter_valid(pl[9]), .i_filter_value(fval), .o_take_synth_irq(take_s),
        .o_take_timer_irq(take_t), .o_irq(irq), .o_predictive_synth_enable(pred),
        .o_sample_mode(samp), .o_ext_speech_mem_enable(extm), .o_synth_enable(syn),
        .o_filter_req(freq), .o_pwm(pwm));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // a hang in any wait loop ends here instead of running forever
    always @(posedge i_clk) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // high cycles of one converter period for a loaded value
    function automatic int unsigned exp_high(input int unsigned v, input int unsigned p);
        return (v * p) >> CONV_W;
    endfunction : exp_high

    // filter requests in n cycles: one per two converter periods
    function automatic int unsigned exp_reqs(input int unsigned n, input int unsigned p);
        return n / (2 * p);
    endfunction : exp_reqs

    // outputs update in the nba region, so right after an edge they still
    // show what that edge sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge i_clk);
        apb_req.penable <= 1'b1;
        do @(posedge i_clk); while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb

    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] msk,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd & msk);
    endtask : rdc

    task automatic pulse(input int b);
        @(posedge i_clk);
        pl[b] <= 1'b1;
        @(posedge i_clk);
        pl[b] <= 1'b0;
    endtask : pulse

    task automatic waitc(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask : waitc

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(57));
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        for (k = 0; k < 6; k++) rdc("reset", ADDR_STATUS + 8'(4 * k), 32'hFFFFFFFF, 32'h0);
        apb(1'b1, ADDR_MODE, 32'hFF);
        rdc("mode_read", ADDR_MODE, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b1, ADDR_PRESCALE, 32'h3);
        apb(1'b1, ADDR_STATUS, 32'h7);
        $display("test reset done");
        for (k = 0; k < 6; k++) begin
            m = (k == 0) ? 0 : (k == 1) ? 32'h1F : ($urandom & 32'h1F);
            apb(1'b1, ADDR_MODE, m);
            waitc(3);
            chk("pred", 32'(m[1]), 32'(pred));
            chk("samp", 32'(m[2]), 32'(samp));
            chk("extm", 32'(m[4]), 32'(extm));
            chk("synth_en", 32'(m[1] | m[2]), 32'(syn));
        end
        $display("test mode done");
        for (k = 0; k < 4; k++) begin
            apb(1'b1, ADDR_MODE, (k << 1) | 1);
            apb(1'b1, ADDR_STATUS, 32'h1);
            for (j = 0; j < 4; j++) if (j != k) pulse(j);
            rdc("other_cond", ADDR_STATUS, 32'h1, 32'h0);
            pulse(k);
            waitc(2);
            chk("take_synth", 32'h1, 32'(take_s));
            pulse(4);
            waitc(2);
            chk("take_synth_clr", 32'h0, 32'(take_s));
        end
        apb(1'b1, ADDR_MODE, 32'h0);
        pulse(0);
        waitc(3);
        chk("held_off", 32'h0, 32'(take_s));
        rdc("pending", ADDR_STATUS, 32'h1, 32'h1);
        apb(1'b1, ADDR_MODE, 32'h1);
        waitc(3);
        chk("late_take", 32'h1, 32'(take_s));
        pulse(4);
        $display("test synth irq done");
        apb(1'b1, ADDR_TIMER, 32'h0);
        apb(1'b0, ADDR_TIMER, 32'h0);
        t1 = rd;
        @(posedge i_clk);
        apb(1'b0, ADDR_TIMER, 32'h0);
        chk("prescale", 32'h1, 32'(8'(rd[7:0] - t1[7:0])));
        apb(1'b1, ADDR_MODE, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h7);
        apb(1'b1, ADDR_TIMER, 32'hFD);
        waitc(20);
        rdc("overflow", ADDR_STATUS, 32'h2, 32'h2);
        apb(1'b1, ADDR_MODE, 32'h8);
        waitc(3);
        chk("take_timer", 32'h1, 32'(take_t));
        apb(1'b1, ADDR_MODE, 32'h9);
        pulse(0);
        waitc(3);
        chk("prio_synth", 32'h1, 32'(take_s));
        chk("prio_timer", 32'h0, 32'(take_t));
        apb(1'b1, ADDR_MODE, 32'h0);
        waitc(3);
        chk("timer_off", 32'h0, 32'(take_t));
        apb(1'b1, ADDR_STATUS, 32'h7);
        $display("test timer done");
        @(posedge i_clk);
        pin <= 1'b1;
        waitc(8);
        rdc("ext_pin", ADDR_STATUS, 32'h4, 32'h4);
        apb(1'b1, ADDR_MASK, 32'h4);
        waitc(2);
        chk("irq_on", 32'h1, 32'(irq));
        apb(1'b1, ADDR_STATUS, 32'h4);
        waitc(2);
        chk("irq_off", 32'h0, 32'(irq));
        pin <= 1'b0;
        apb(1'b1, ADDR_MASK, 32'h0);
        $display("test ext done");
        t1 = $urandom & 32'h3FFF;
        apb(1'b1, ADDR_TEMP, t1);
        pulse(4);
        apb(1'b1, ADDR_TEMP, ~t1 & 32'h3FFF);
        pulse(6);
        rdc("temp_restore", ADDR_TEMP, 32'hFFFFFFFF, t1);
        t2 = $urandom & 32'hFF;
        apb(1'b1, ADDR_INDEX, t2);
        pulse(7);
        rdc("swap_index", ADDR_INDEX, 32'hFFFFFFFF, t1 & 32'hFF);
        rdc("swap_tempx", ADDR_TEMP, 32'hFFFFFFFF, t2);
        t2 = $urandom & 32'h3FFF;
        apb(1'b1, ADDR_ACCUM, t2);
        apb(1'b1, ADDR_TEMP, t1);
        pulse(8);
        rdc("swap_accum", ADDR_ACCUM, 32'hFFFFFFFF, t1);
        rdc("swap_tempa", ADDR_TEMP, 32'hFFFFFFFF, t2);
        $display("test temp done");
        t1 = $urandom & 32'h3FF;
        apb(1'b1, ADDR_MODE, 32'h4);
        apb(1'b1, ADDR_CONV, t1);
        rdc("conv_direct", ADDR_CONV, 32'hFFFFFFFF, t1);
        waitc(45);
        k = 0;
        repeat (400) begin
            @(negedge i_clk);
            if (pwm === 1'b1) k++;
        end
        chk("pwm_duty", 10 * exp_high(t1, 40), k);
        apb(1'b1, ADDR_MODE, 32'h2);
        apb(1'b1, ADDR_CONV, ~t1 & 32'h3FF);
        rdc("conv_locked", ADDR_CONV, 32'hFFFFFFFF, t1);
        fval <= 10'($urandom);
        pulse(9);
        rdc("conv_filter", ADDR_CONV, 32'hFFFFFFFF, 32'(fval));
        for (j = 0; j < 2; j++) begin
            apb(1'b1, ADDR_CONFIG, j);
            k = 0;
            repeat (800) begin
                @(negedge i_clk);
                if (freq === 1'b1) k++;
            end
            m = exp_reqs(800, j ? 50 : 40);
            chk("filter_rate", 32'h1, 32'(k + 1 >= m && k <= m + 1));
        end
        $display("test converter done");
        give_verdict();
    end
endmodule : tb_top
